//--- rtl/serial_port_zero.sv
// Purpose: Full-duplex asynchronous serial port with APB registers
// Assumes: pclk 20 MHz; far end uses the same bit rate
// Notes: One wait state on every APB access
//
// Our own choice: the APB interface to the registers.
`default_nettype none
`include "serial_port_defines.svh"
module serial_port_zero
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire logic rx_pin,
    output logic tx_pin,
    // Timer clock inputs
    input wire logic ext_osc_in,
    input wire logic baud_timer_ext_input,
    // Interrupt request
    output logic irq
);
    function automatic logic hit(input logic [11:0] addr, input logic [9:0] index);
        hit = (addr == {index, 2'b00});
    endfunction

    baud_if bt();
    logic [2:0] pins_s;
    logic rx_s;
    logic rx_prev_reg;

    input_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({baud_timer_ext_input, ext_osc_in, rx_pin}),
        .sync_out(pins_s)
    );

    baud_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .ext_osc_s(pins_s[1]),
        .ext_pin_s(pins_s[2]),
        .bt(bt)
    );

    assign rx_s = pins_s[0];

    // Registers
    logic [7:0] ctrl_reg;
    byte_t reload_reg;
    clk_src_e src_reg;
    logic run_reg;
    logic irq_en_reg;
    byte_t rx_buf_reg;

    // APB decode
    logic access, wr, rd, sel_ctrl, sel_data, sel_baud, mapped;
    assign access = psel && penable && pready;
    assign sel_ctrl = hit(paddr, `CTRL_INDEX);
    assign sel_data = hit(paddr, `DATA_INDEX);
    assign sel_baud = hit(paddr, `BAUD_INDEX);
    assign mapped = sel_ctrl || sel_data || sel_baud;
    assign wr = access && pwrite && mapped && pstrb[0];
    assign rd = access && !pwrite;

    assign bt.run = run_reg;
    assign bt.reload = reload_reg;
    assign bt.src = src_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready && !pwrite) begin
            if (sel_ctrl) begin
                prdata <= {24'h00_0000, ctrl_reg};
            end else if (sel_data) begin
                prdata <= {24'h00_0000, rx_buf_reg};
            end else if (sel_baud) begin
                prdata <= {8'h00, bt.count_low, 3'h0, irq_en_reg, run_reg, src_reg, reload_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_reg <= 8'h00;
            src_reg <= SRC_SYS;
            run_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end else if (wr && sel_baud) begin
            reload_reg <= pwdata[`BAUD_RELOAD_LSB +: 8];
            src_reg <= clk_src_e'(pwdata[`BAUD_SRC_LSB +: 3]);
            run_reg <= pwdata[`BAUD_RUN];
            irq_en_reg <= pwdata[`BAUD_IRQ_EN];
        end
    end

    // Transmitter
    frame_state_e tx_state_reg;
    logic [8:0] tx_shift_reg;
    logic [2:0] tx_cnt_reg;
    logic tx_pending_reg;
    logic tx_set;
    logic data_wr;
    logic mode9;

    assign data_wr = wr && sel_data;
    assign mode9 = ctrl_reg[`CTRL_MODE];

    // A write mid-frame waits for the next bit boundary, then restarts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pending_reg <= 1'b0;
            tx_shift_reg <= 9'h000;
        end else if (data_wr) begin
            tx_pending_reg <= 1'b1;
            tx_shift_reg <= {ctrl_reg[`CTRL_TB8], pwdata[7:0]};
        end else if (bt.tx_bit_tick) begin
            if (tx_pending_reg) begin
                tx_pending_reg <= 1'b0;
            end else if (tx_state_reg == ST_DATA) begin
                tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= ST_IDLE;
            tx_cnt_reg <= 3'h0;
            tx_pin <= 1'b1;
        end else if (bt.tx_bit_tick && !data_wr) begin
            if (tx_pending_reg) begin
                tx_state_reg <= ST_START;
                tx_pin <= 1'b0;
            end else begin
                case (tx_state_reg)
                    ST_START: begin
                        tx_state_reg <= ST_DATA;
                        tx_cnt_reg <= 3'h0;
                        tx_pin <= tx_shift_reg[0];
                    end
                    ST_DATA: begin
                        if (tx_cnt_reg == `DATA_BITS_LAST) begin
                            tx_state_reg <= mode9 ? ST_NINTH : ST_STOP;
                            tx_pin <= mode9 ? tx_shift_reg[1] : 1'b1;
                        end else begin
                            tx_cnt_reg <= tx_cnt_reg + 3'h1;
                            tx_pin <= tx_shift_reg[1];
                        end
                    end
                    ST_NINTH: begin
                        tx_state_reg <= ST_STOP;
                        tx_pin <= 1'b1;
                    end
                    ST_STOP: begin
                        tx_state_reg <= ST_IDLE;
                        tx_pin <= 1'b1;
                    end
                    default: begin
                        tx_state_reg <= ST_IDLE;
                        tx_pin <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Flag rises as the stop bit begins
    assign tx_set = bt.tx_bit_tick && !data_wr && !tx_pending_reg && (((tx_state_reg == ST_DATA) &&
        (tx_cnt_reg == `DATA_BITS_LAST) && !mode9) || (tx_state_reg == ST_NINTH));

    // Receiver
    frame_state_e rx_state_reg;
    logic [7:0] rx_shift_reg;
    logic rx_ninth_reg;
    logic [2:0] rx_cnt_reg;
    logic rx_load;
    logic rx_filter_bit;

    assign bt.rx_restart = (rx_state_reg == ST_IDLE) && ctrl_reg[`CTRL_REN] && rx_prev_reg && !rx_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_reg <= 1'b1;
        end else begin
            rx_prev_reg <= rx_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg <= ST_IDLE;
            rx_cnt_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_ninth_reg <= 1'b0;
        end else if (bt.rx_restart) begin
            rx_state_reg <= ST_START;
        end else if (bt.rx_bit_tick) begin
            case (rx_state_reg)
                ST_START: begin
                    rx_state_reg <= rx_s ? ST_IDLE : ST_DATA;
                    rx_cnt_reg <= 3'h0;
                end
                ST_DATA: begin
                    rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
                    if (rx_cnt_reg == `DATA_BITS_LAST) begin
                        rx_state_reg <= mode9 ? ST_NINTH : ST_STOP;
                    end else begin
                        rx_cnt_reg <= rx_cnt_reg + 3'h1;
                    end
                end
                ST_NINTH: begin
                    rx_ninth_reg <= rx_s;
                    rx_state_reg <= ST_STOP;
                end
                ST_STOP: rx_state_reg <= ST_IDLE;
                default: rx_state_reg <= ST_IDLE;
            endcase
        end
    end

    // Stop bit in 8-bit mode, ninth bit in 9-bit mode
    assign rx_filter_bit = mode9 ? rx_ninth_reg : rx_s;
    assign rx_load = bt.rx_bit_tick && !bt.rx_restart && (rx_state_reg == ST_STOP) && !ctrl_reg[`CTRL_RI] &&
        (!ctrl_reg[`CTRL_MCE] || rx_filter_bit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_reg <= 8'h00;
        end else if (rx_load) begin
            rx_buf_reg <= rx_shift_reg;
        end
    end

    // Control register; hardware sets win over a same-cycle software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
        end else begin
            if (wr && sel_ctrl) begin
                ctrl_reg <= pwdata[7:0] | `CTRL_RESET;
            end
            if (rx_load) begin
                ctrl_reg[`CTRL_RB8] <= rx_filter_bit;
                ctrl_reg[`CTRL_RI] <= 1'b1;
            end
            if (tx_set) begin
                ctrl_reg[`CTRL_TI] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_en_reg && (ctrl_reg[`CTRL_TI] || ctrl_reg[`CTRL_RI]);
        end
    end
endmodule
`default_nettype wire

//--- rtl/serial_port_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the serial port
// Assumes: APB byte address is four times the register index
// Notes: Definitions only
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH
`define CTRL_INDEX 10'h098
`define DATA_INDEX 10'h099
`define BAUD_INDEX 10'h0A0
`define CTRL_RESET 8'h40
`define CTRL_MODE 7
`define CTRL_ONE 6
`define CTRL_MCE 5
`define CTRL_REN 4
`define CTRL_TB8 3
`define CTRL_RB8 2
`define CTRL_TI 1
`define CTRL_RI 0
`define BAUD_RELOAD_LSB 0
`define BAUD_SRC_LSB 8
`define BAUD_RUN 11
`define BAUD_IRQ_EN 12
`define BAUD_COUNT_LSB 16
`define PRESCALE_LAST 6'h2F
`define EXT_DIV_LAST 3'h7
`define TIMER_TOP 8'hFF
`define DATA_BITS_LAST 3'h7
`endif

//--- rtl/serial_port_pkg.sv
// Purpose: Types shared by the serial port modules
// Assumes: Nothing beyond the defines header
// Notes: States are Gray coded from idle to stop along the 9-bit frame path
`default_nettype none
package serial_port_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_START = 3'h1, ST_DATA = 3'h3, ST_NINTH = 3'h2, ST_STOP = 3'h6
    } frame_state_e;
    typedef enum logic [2:0] {
        SRC_SYS = 3'h0, SRC_DIV4 = 3'h1, SRC_DIV12 = 3'h2, SRC_DIV48 = 3'h3, SRC_EXT8 = 3'h4, SRC_PIN = 3'h5
    } clk_src_e;
    typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

//--- rtl/baud_if.sv
// Purpose: Links the port core to its baud timer
// Assumes: Single clock domain
// Notes: Ticks are one-cycle pulses
`default_nettype none
interface baud_if;
    import serial_port_pkg::*;
    logic run;
    byte_t reload;
    clk_src_e src;
    logic rx_restart;
    logic tx_bit_tick;
    logic rx_bit_tick;
    byte_t count_low;
    modport timer(input run, reload, src, rx_restart, output tx_bit_tick, rx_bit_tick, count_low);
    modport user(output run, reload, src, rx_restart, input tx_bit_tick, rx_bit_tick, count_low);
endinterface
`default_nettype wire

//--- rtl/input_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs idle high
// Notes: Output moves only when stages two and three agree
`default_nettype none
module input_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);
    logic [2:0] s1_reg, s2_reg, s3_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
            s3_reg <= 3'h7;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= 3'h7;
        end else begin
            sync_out <= (s2_reg & s3_reg) | (sync_out & (s2_reg ^ s3_reg));
        end
    end
endmodule
`default_nettype wire

//--- rtl/baud_timer.sv
// Purpose: Baud timer clock select, transmit timer and its receive copy
// Assumes: Pin sources already synchronised
// Notes: Overflows halved into bit ticks
`default_nettype none
`include "serial_port_defines.svh"
module baud_timer
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Synchronised clock sources
    input wire logic ext_osc_s,
    input wire logic ext_pin_s,
    // Core side
    baud_if.timer bt
);
    logic [5:0] pre_reg;
    logic [2:0] ext_cnt_reg;
    logic osc_prev_reg, pin_prev_reg;
    logic tick;
    byte_t rx_cnt_reg;
    logic tx_half_reg, rx_half_reg;
    logic tx_ovf, rx_ovf;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 6'h00;
            ext_cnt_reg <= 3'h0;
            osc_prev_reg <= 1'b1; // Synchroniser resets high; avoids a false edge
            pin_prev_reg <= 1'b1;
        end else begin
            pre_reg <= (pre_reg == `PRESCALE_LAST) ? 6'h00 : pre_reg + 6'h01;
            osc_prev_reg <= ext_osc_s;
            pin_prev_reg <= ext_pin_s;
            if (ext_osc_s && !osc_prev_reg) begin
                ext_cnt_reg <= ext_cnt_reg + 3'h1;
            end
        end
    end

    always_comb begin
        case (bt.src)
            SRC_SYS: tick = 1'b1;
            SRC_DIV4: tick = (pre_reg[1:0] == 2'h3);
            SRC_DIV12: tick = (pre_reg == 6'h0B) || (pre_reg == 6'h17) || (pre_reg == 6'h23) || (pre_reg == 6'h2F);
            SRC_DIV48: tick = (pre_reg == `PRESCALE_LAST);
            SRC_EXT8: tick = ext_osc_s && !osc_prev_reg && (ext_cnt_reg == `EXT_DIV_LAST);
            SRC_PIN: tick = !ext_pin_s && pin_prev_reg;
            default: tick = 1'b0;
        endcase
    end

    // Rate is source / (256 - reload)
    assign tx_ovf = bt.run && tick && (bt.count_low == `TIMER_TOP);
    assign rx_ovf = bt.run && tick && (rx_cnt_reg == `TIMER_TOP);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bt.count_low <= 8'h00;
            tx_half_reg <= 1'b0;
            bt.tx_bit_tick <= 1'b0;
        end else begin
            if (bt.run && tick) begin
                bt.count_low <= tx_ovf ? bt.reload : bt.count_low + 8'h01;
            end
            if (tx_ovf) begin
                tx_half_reg <= !tx_half_reg;
            end
            bt.tx_bit_tick <= tx_ovf && tx_half_reg;
        end
    end

    // Restart makes the first tick land half a bit later, at mid start bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_reg <= 8'h00;
            rx_half_reg <= 1'b0;
            bt.rx_bit_tick <= 1'b0;
        end else if (bt.rx_restart) begin
            rx_cnt_reg <= bt.reload;
            rx_half_reg <= 1'b1;
            bt.rx_bit_tick <= 1'b0;
        end else begin
            if (bt.run && tick) begin
                rx_cnt_reg <= rx_ovf ? bt.reload : rx_cnt_reg + 8'h01;
            end
            if (rx_ovf) begin
                rx_half_reg <= !rx_half_reg;
            end
            bt.rx_bit_tick <= rx_ovf && rx_half_reg;
        end
    end
endmodule
`default_nettype wire

//--- verif/serial_port_zero_props.sv
// Purpose: Port-level properties of the serial port
// Assumes: APB master holds each request until pready
// Notes: Flag history is tracked through control reads only
`default_nettype none
`include "serial_port_defines.svh"
module serial_port_zero_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic tx_pin,
    input wire logic irq
);
    localparam logic [11:0] CTRL = {`CTRL_INDEX, 2'b00};
    localparam logic [11:0] DATA = {`DATA_INDEX, 2'b00};
    localparam logic [11:0] BAUD = {`BAUD_INDEX, 2'b00};
    logic done_rd;
    logic done_wr;
    logic en_reg;
    logic dirty_reg;
    logic sent_reg;
    logic [1:0] seen_reg;
    assign done_rd = psel && penable && pready && !pwrite;
    assign done_wr = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 1'b0;
        end else if (done_wr && paddr == BAUD && pstrb[0]) begin
            en_reg <= pwdata[`BAUD_IRQ_EN];
        end
    end
    // A software write may clear flags, so history restarts after one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_reg <= 2'b00;
            dirty_reg <= 1'b0;
        end else if (done_wr && paddr == CTRL) begin
            dirty_reg <= 1'b1;
        end else if (done_rd && paddr == CTRL) begin
            seen_reg <= prdata[1:0];
            dirty_reg <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sent_reg <= 1'b0;
        end else if (done_wr && paddr == DATA) begin
            sent_reg <= 1'b1;
        end
    end
    reset_outs_a: assert property (@(posedge pclk) !presetn ##1 !presetn |->
        tx_pin && !irq && !pready && !pslverr && prdata == 32'h0000_0000) else $error("bad reset outputs");
    wait_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && $rose(penable) |-> !pready ##1 pready) else $error("wait state wrong");
    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready && psel && penable) else $error("error outside access");
    err_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> prdata == 32'h0000_0000) else $error("refused access returned data");
    ctrl_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_rd && paddr == CTRL |-> prdata[6] && prdata[31:8] == 24'h00_0000) else $error("control bit six");
    data_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_rd && paddr == DATA |-> prdata[31:8] == 24'h00_0000) else $error("data read too wide");
    flags_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_rd && paddr == CTRL && !dirty_reg |-> (prdata[1:0] & seen_reg) == seen_reg) else $error("flag lost");
    irq_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
        !en_reg && !$past(en_reg) |-> !irq) else $error("irq while disabled");
    irq_raised_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_rd && paddr == CTRL && en_reg && prdata[1:0] != 2'b00 |-> ##[0:2] irq) else $error("irq missing");
    tx_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sent_reg |-> tx_pin) else $error("tx moved before a data write");
endmodule
bind serial_port_zero serial_port_zero_checker props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_pin(tx_pin), .irq(irq));
`default_nettype wire

//--- verif/remote_port.sv
// Purpose: Far-end serial port model
// Assumes: Same bit time as the block under test
// Notes: Captures ten bits after each start edge
`default_nettype none
module remote_port #(
    parameter int BITC = 16
) (
    // Clock
    input wire logic pclk,
    // Serial lines
    output logic tx_line,
    input wire logic rx_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] got = '0;
    int n_got = 0;
    initial tx_line = 1'b1;
    // Eleven bit slots; in 8-bit frames the last is idle high
    task automatic send(input logic [7:0] d, input logic nine, input logic b9, input logic stop);
        logic [10:0] f;
        f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            tx_line <= f[i];
            repeat (BITC) @(posedge pclk);
        end
        tx_line <= 1'b1;
    endtask
    always begin
        @(negedge rx_line);
        repeat (BITC / 2) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            repeat (BITC) @(posedge pclk);
            got[i] = rx_line;
        end
        n_got++;
    end
endmodule
`default_nettype wire

//--- verif/tb_serial_port_zero.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Peer model runs at the programmed bit time
// Notes: Timer pin source pulsed three times; oscillator input held low
`default_nettype none
`include "serial_port_defines.svh"
module tb_serial_port_zero;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] CTRL = {`CTRL_INDEX, 2'b00};
    localparam logic [11:0] DATA = {`DATA_INDEX, 2'b00};
    localparam logic [11:0] BAUD = {`BAUD_INDEX, 2'b00};
    localparam logic [7:0] RELOAD = 8'hF8;
    localparam logic [31:0] CFG = {19'h0_0000, 1'b1, 1'b1, 3'h0, RELOAD};
    // Short bit time keeps every frame under two hundred clocks
    localparam int BITC = 2 * (256 - RELOAD);
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_pin, tx_pin, irq, perr, ext_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    int n_errors = 0;
    int tests_run = 0;
    serial_port_zero uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_pin(rx_pin), .tx_pin(tx_pin), .ext_osc_in(1'b0), .baud_timer_ext_input(ext_pin), .irq(irq));
    remote_port #(.BITC(BITC)) peer (.pclk(pclk), .tx_line(rx_pin), .rx_line(tx_pin));
    always #25 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        apb(0, CTRL, '0);
        chk(rdata, 32'h0000_0040);
        apb(1, CTRL, '0);
        apb(0, CTRL, '0);
        chk(rdata, 32'h0000_0040);
        apb(0, 12'h7F0, '0);
        chk({31'h0000_0000, perr}, 32'h0000_0001);
        chk(rdata, 32'h0000_0000);
        apb(1, BAUD, CFG);
        apb(0, BAUD, '0);
        chk({16'h0000, rdata[15:0]}, {16'h0000, CFG[15:0]});
        $display("test regs done");
    endtask
    task automatic t_tx(input logic nine, input logic b9, input logic [7:0] d);
        int n0;
        apb(1, CTRL, {24'h00_0000, nine, 3'b000, b9, 3'b000});
        n0 = peer.n_got;
        apb(1, DATA, {24'h00_0000, d});
        while (peer.n_got == n0) begin
            @(posedge pclk);
        end
        chk({22'h00_0000, peer.got}, nine ? {22'h00_0000, 1'b1, b9, d} : {22'h00_0000, 2'b11, d});
        apb(0, CTRL, '0);
        apb(0, CTRL, '0);
        chk({30'h0000_0000, irq, rdata[1]}, 32'h0000_0003);
        apb(1, CTRL, '0);
        apb(0, CTRL, '0);
        chk({29'h0000_0000, irq, rdata[1], tx_pin}, 32'h0000_0001);
        $display("test tx %h done", d);
    endtask
    task automatic t_rx(input logic [7:0] c, input logic [7:0] d, input logic [2:0] f, input logic [2:0] e,
        input logic [7:0] ed);
        if (c != 8'h00) begin
            apb(1, CTRL, {24'h00_0000, c});
        end
        peer.send(d, f[2], f[1], f[0]);
        repeat (8) @(posedge pclk);
        apb(0, CTRL, '0);
        chk({29'h0000_0000, rdata[2:0]}, {29'h0000_0000, e});
        apb(0, DATA, '0);
        chk(rdata, {24'h00_0000, ed});
        $display("test rx %h done", d);
    endtask
    // Pin source: three falling edges must add exactly three counts
    task automatic t_src;
        logic [7:0] c0;
        apb(1, BAUD, 32'h0000_0D00);
        apb(0, BAUD, '0);
        c0 = rdata[`BAUD_COUNT_LSB +: 8];
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        repeat (3) begin
            ext_pin <= 1'b0;
            repeat (6) @(posedge pclk);
            ext_pin <= 1'b1;
            repeat (6) @(posedge pclk);
        end
        apb(0, BAUD, '0);
        chk({24'h00_0000, rdata[`BAUD_COUNT_LSB +: 8] - c0}, 32'h0000_0003);
        apb(1, BAUD, CFG);
        apb(0, CTRL, '0);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        $display("test source done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ext_pin = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx(1'b0, 1'b0, 8'hA5);
        t_tx(1'b1, 1'b1, 8'h5A);
        t_tx(1'b1, 1'b0, 8'h3C);
        t_rx(8'h40, 8'h11, 3'b001, 3'b000, 8'h00);
        t_rx(8'h10, 8'h3C, 3'b001, 3'b101, 8'h3C);
        t_src();
        t_rx(8'h00, 8'h77, 3'b001, 3'b101, 8'h3C);
        t_rx(8'h30, 8'h55, 3'b000, 3'b000, 8'h3C);
        t_rx(8'hB0, 8'h66, 3'b101, 3'b000, 8'h3C);
        t_rx(8'h00, 8'h99, 3'b110, 3'b101, 8'h99);
        t_rx(8'h90, 8'h42, 3'b101, 3'b001, 8'h42);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
